// ---- pum_cfg.svh ----
/*
 * Constants of the ungated PRBS error measurement block: lane counts, counter
 * widths, encodings and refresh timing.
 * Assumes inclusion by bare name from every file that needs them.
 */
`ifndef PUM_CFG_SVH
`define PUM_CFG_SVH

// ****************************************************************
// Lanes and widths
// ****************************************************************
`define PUM_SIDE_LANES      8
`define PUM_LANES           16
`define PUM_LANE_IDX_W      4
`define PUM_ERR_W           32
`define PUM_BIT_W           48
`define PUM_GATE_W          3
`define PUM_GATE_UNGATED    3'h0

// ****************************************************************
// Refresh timing
// ****************************************************************
`define PUM_CLK_HZ          250000000
`define PUM_REFRESH_SHORT_S 1
`define PUM_REFRESH_LONG_S  5
`define PUM_REFRESH_SHORT_CYC (`PUM_REFRESH_SHORT_S * `PUM_CLK_HZ)
`define PUM_REFRESH_LONG_CYC  (`PUM_REFRESH_LONG_S * `PUM_CLK_HZ)

`endif

// ---- pum_pkg.sv ----
/*
 * Types shared by the ungated PRBS error measurement block.
 * Assumes pum_cfg.svh is on the include path.
 */
`include "pum_cfg.svh"

package pum_pkg;
  typedef logic [`PUM_ERR_W-1:0] pum_err_t;
  typedef logic [`PUM_BIT_W-1:0] pum_bits_t;
  typedef enum logic {
    pum_run,
    pum_freeze
  } pum_phase_t;
endpackage

// ---- pum_lane_if.sv ----
/*
 * Link between the measurement control and one lane's live counters.
 * Assumes pum_pkg is compiled first.
 */
`timescale 1ns/1ns

interface pum_lane_if;
  logic               clear;
  logic               count_en;
  logic               err_hit;
  logic               bit_hit;
  pum_pkg::pum_err_t  err_cnt;
  pum_pkg::pum_bits_t bit_cnt;

  modport ctrl (output clear, output count_en, output err_hit, output bit_hit,
                input err_cnt, input bit_cnt);
  modport cnt  (input clear, input count_en, input err_hit, input bit_hit,
                output err_cnt, output bit_cnt);
endinterface

// ---- pum_refresh_timer.sv ----
/*
 * Interim refresh timer: one-cycle tick every 1 s or 5 s of clk_in.
 * Assumes a 250 MHz clock and a synchronous active-low reset.
 */
`timescale 1ns/1ns
`include "pum_cfg.svh"

module pum_refresh_timer #(
  parameter int unsigned SHORT_CYC = `PUM_REFRESH_SHORT_CYC,
  parameter int unsigned LONG_CYC  = `PUM_REFRESH_LONG_CYC
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Control
  input  wire logic run_in,
  input  wire logic long_in,
  // Tick
  output logic      tick_out
);
  logic [31:0] cnt_reg;
  logic        long_reg;
  logic        tick_reg;
  wire  [31:0] limit_w   = long_in ? 32'(LONG_CYC) : 32'(SHORT_CYC);
  // A changed interval restarts the period so no short stray period appears
  wire         restart_w = !run_in || (long_in != long_reg);
  wire         wrap_w    = cnt_reg >= limit_w - 32'h1;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || restart_w) begin
      cnt_reg  <= 32'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= wrap_w ? 32'h0 : cnt_reg + 32'h1;
      tick_reg <= wrap_w;
    end
    long_reg <= rst_n_in ? long_in : 1'b0;
  end

  assign tick_out = tick_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_TICK_SPACING: assert property (tick_out && run_in && $stable(long_in) |=> !tick_out)
    else $error("refresh tick repeated on consecutive cycles");
endmodule

// ---- pum_lane_counter.sv ----
/*
 * Live error and bit counters of one checker lane, saturating.
 * Assumes the control side drives the lane interface synchronously.
 */
`timescale 1ns/1ns
`include "pum_cfg.svh"

module pum_lane_counter (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Lane link
  pum_lane_if.cnt   lane
);
  pum_pkg::pum_err_t  err_reg;
  pum_pkg::pum_bits_t bit_reg;

  // Saturate so a long run never wraps to a misleading small count
  function automatic pum_pkg::pum_bits_t sat_inc(input pum_pkg::pum_bits_t v,
                                                  input pum_pkg::pum_bits_t top);
    sat_inc = (v == top) ? v : v + 48'h1;
  endfunction

  wire pum_pkg::pum_bits_t err_ext_w  = {16'h0, err_reg};
  wire pum_pkg::pum_bits_t err_inc_w  = sat_inc(err_ext_w, 48'h0000FFFFFFFF);
  wire pum_pkg::pum_bits_t bit_inc_w  = sat_inc(bit_reg, 48'hFFFFFFFFFFFF);

  always_ff @(posedge clk_in) begin
    if (!rst_n_in || lane.clear) begin
      err_reg <= 32'h0;
      bit_reg <= 48'h0;
    end else if (lane.count_en) begin
      if (lane.err_hit) err_reg <= err_inc_w[31:0];
      if (lane.bit_hit) bit_reg <= bit_inc_w;
    end
  end

  assign lane.err_cnt = err_reg;
  assign lane.bit_cnt = bit_reg;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_COUNT_STEP: assert property (lane.count_en && lane.err_hit && !lane.clear
      && err_reg != 32'hFFFFFFFF |=> err_reg == $past(err_reg) + 32'h1)
    else $error("error counter did not step by one");
endmodule

// ---- pum_top.sv ----
/*
 * Ungated PRBS error measurement control: per-lane live counters for eight
 * host-side and eight media-side checkers, published results and a
 * previous-period copy, read back by lane index.
 * Assumes checker enables, events and configuration bits are synchronous to
 * clk_in, one event per lane per cycle at most.
 */
//
// Function
// - Gate time field zero means ungated mode, counting runs until host stops.
// - The gate auto-rearm bit has no effect in ungated mode.
// - With interim capability, published results are cumulative and refreshed.
// - No flag marks interim refreshes; the host must poll.
// - Without interim capability a run is single-shot, results at stop.
// - Newly enabled lanes clear their counters then start counting.
// - Disabling a lane stops counting and publishes to primary and previous.
// - Without interim capability no refresh; results only at disable or at clear-bit rise.
// - With interim capability, primary results refresh at the chosen interval.
// - Interval bit zero selects one second, one selects five seconds.
// - Bit counts are kept beside error counts.
// - Local scope: clearing results restarts only the enabled lanes.
// - Global scope: clearing results restarts every lane.
// - Before a global clear, copy results into primary and previous.
// - After global clear primary restarts, previous keeps pre-clear results.
// - While the clear bit is one, enabled counters freeze and stay readable.
// - Returning the clear bit to zero clears enabled lanes' results.
`timescale 1ns/1ns
`include "pum_cfg.svh"

module pum_top #(
  parameter int unsigned REFRESH_SHORT_CYC = `PUM_REFRESH_SHORT_CYC,
  parameter int unsigned REFRESH_LONG_CYC  = `PUM_REFRESH_LONG_CYC
) (
  // Clock and reset
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  // Checker enables
  input  wire logic [`PUM_SIDE_LANES-1:0]  host_chk_en_in,
  input  wire logic [`PUM_SIDE_LANES-1:0]  media_chk_en_in,
  // Checker events
  input  wire logic [`PUM_SIDE_LANES-1:0]  host_err_in,
  input  wire logic [`PUM_SIDE_LANES-1:0]  media_err_in,
  input  wire logic [`PUM_SIDE_LANES-1:0]  host_bit_in,
  input  wire logic [`PUM_SIDE_LANES-1:0]  media_bit_in,
  // Measurement configuration
  input  wire logic [`PUM_GATE_W-1:0]      gate_time_select_in,
  input  wire logic                        gate_auto_rearm_in,
  input  wire logic                        interim_update_capable_in,
  input  wire logic                        interim_refresh_interval_in,
  input  wire logic                        reset_scope_all_banks_in,
  input  wire logic                        clear_error_results_in,
  // Result read
  input  wire logic [`PUM_LANE_IDX_W-1:0]  rd_lane_in,
  input  wire logic                        rd_prev_in,
  output logic      [`PUM_ERR_W-1:0]       rd_err_out,
  output logic      [`PUM_BIT_W-1:0]       rd_bits_out,
  // Status
  output logic                             frozen_out
);

  // ****************************************************************
  // Lane view and edge detection
  // ****************************************************************
  logic [`PUM_LANES-1:0] en_reg;
  logic                  clr_reg;
  pum_pkg::pum_phase_t   phase_reg;
  pum_pkg::pum_phase_t   phase_next;

  wire [`PUM_LANES-1:0] en_w     = {media_chk_en_in, host_chk_en_in};
  wire [`PUM_LANES-1:0] err_w    = {media_err_in, host_err_in};
  wire [`PUM_LANES-1:0] bit_w    = {media_bit_in, host_bit_in};
  wire [`PUM_LANES-1:0] en_rise  = en_w & ~en_reg;
  wire [`PUM_LANES-1:0] en_fall  = ~en_w & en_reg;
  wire                  clr_rise = clear_error_results_in && !clr_reg;
  wire                  clr_fall = !clear_error_results_in && clr_reg;
  // Only the zero code runs here; gate_auto_rearm_in is deliberately unused
  wire                  ungated  = gate_time_select_in == `PUM_GATE_UNGATED;
  wire                  hold_w   = clear_error_results_in || phase_reg == pum_pkg::pum_freeze;
  wire                  scope_w  = reset_scope_all_banks_in;
  wire                  tick_w;

  // ****************************************************************
  // Freeze phase of the clear bit
  // ****************************************************************
  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      pum_pkg::pum_run: begin
        if (clr_rise) phase_next = pum_pkg::pum_freeze;
      end
      pum_pkg::pum_freeze: begin
        if (clr_fall) phase_next = pum_pkg::pum_run;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      en_reg    <= 16'h0000;
      clr_reg   <= 1'b0;
      phase_reg <= pum_pkg::pum_run;
    end else begin
      en_reg    <= en_w;
      clr_reg   <= clear_error_results_in;
      phase_reg <= phase_next;
    end
  end

  assign frozen_out = phase_reg == pum_pkg::pum_freeze;

  // ****************************************************************
  // Interim refresh timing
  // ****************************************************************
  // Refresh updates nothing but result storage; no flag is raised for it
  pum_refresh_timer #(
    .SHORT_CYC (REFRESH_SHORT_CYC),
    .LONG_CYC  (REFRESH_LONG_CYC)
  ) i_pum_refresh_timer (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .run_in   (interim_update_capable_in && ungated),
    .long_in  (interim_refresh_interval_in),
    .tick_out (tick_w)
  );

  // ****************************************************************
  // Per-lane control and live counters
  // ****************************************************************
  pum_lane_if lane_if [`PUM_LANES] ();

  logic [`PUM_LANES-1:0] count_en_w;
  logic [`PUM_LANES-1:0] clear_w;
  logic [`PUM_LANES-1:0] pub_pri_w;
  logic [`PUM_LANES-1:0] pub_prev_w;
  pum_pkg::pum_err_t     live_err_w [`PUM_LANES];
  pum_pkg::pum_bits_t    live_bit_w [`PUM_LANES];

  for (genvar i = 0; i < `PUM_LANES; i++) begin : g_lane
    // Freeze applies from the cycle the bit is seen, so the copy taken at
    // the rising edge matches what stays frozen afterwards
    assign count_en_w[i] = en_w[i] && ungated && !hold_w;
    // Rising enable clears; release of the clear bit clears enabled lanes or,
    // with global scope, every lane
    assign clear_w[i]    = en_rise[i] || (clr_fall && (scope_w || en_w[i]));
    // Interim refresh only with capability; otherwise only stop and freeze publish
    assign pub_pri_w[i]  = en_fall[i]
                        || (interim_update_capable_in && tick_w && count_en_w[i])
                        || (clr_rise && (scope_w || en_w[i]));
    assign pub_prev_w[i] = en_fall[i] || (clr_rise && scope_w);

    assign lane_if[i].clear    = clear_w[i];
    assign lane_if[i].count_en = count_en_w[i];
    assign lane_if[i].err_hit  = err_w[i];
    assign lane_if[i].bit_hit  = bit_w[i];
    assign live_err_w[i]       = lane_if[i].err_cnt;
    assign live_bit_w[i]       = lane_if[i].bit_cnt;

    pum_lane_counter i_pum_lane_counter (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .lane     (lane_if[i])
    );
  end

  // ****************************************************************
  // Published results
  // ****************************************************************
  pum_pkg::pum_err_t  pri_err_reg  [`PUM_LANES];
  pum_pkg::pum_bits_t pri_bits_reg [`PUM_LANES];
  pum_pkg::pum_err_t  prv_err_reg  [`PUM_LANES];
  pum_pkg::pum_bits_t prv_bits_reg [`PUM_LANES];

  always_ff @(posedge clk_in) begin
    for (int k = 0; k < `PUM_LANES; k++) begin
      if (!rst_n_in) begin
        pri_err_reg[k]  <= 32'h0;
        pri_bits_reg[k] <= 48'h0;
      end else if (pub_pri_w[k]) begin
        pri_err_reg[k]  <= live_err_w[k];
        pri_bits_reg[k] <= live_bit_w[k];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    for (int k = 0; k < `PUM_LANES; k++) begin
      if (!rst_n_in) begin
        prv_err_reg[k]  <= 32'h0;
        prv_bits_reg[k] <= 48'h0;
      end else if (pub_prev_w[k]) begin
        prv_err_reg[k]  <= live_err_w[k];
        prv_bits_reg[k] <= live_bit_w[k];
      end
    end
  end

  // ****************************************************************
  // Result read port
  // ****************************************************************
  // Read data lags the index by one cycle; the host polls, nothing is pushed
  wire pum_pkg::pum_err_t  rd_err_next  = rd_prev_in ? prv_err_reg[rd_lane_in]
                                                     : pri_err_reg[rd_lane_in];
  wire pum_pkg::pum_bits_t rd_bits_next = rd_prev_in ? prv_bits_reg[rd_lane_in]
                                                     : pri_bits_reg[rd_lane_in];

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_err_out  <= 32'h0;
      rd_bits_out <= 48'h0;
    end else begin
      rd_err_out  <= rd_err_next;
      rd_bits_out <= rd_bits_next;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_clear_pulse;
    clear_error_results_in ##1 !clear_error_results_in;
  endsequence

  sequence s_freeze_entry;
    !clear_error_results_in ##1 clear_error_results_in;
  endsequence

  // Enable rise followed by a counted event; ties the clear to the restart
  sequence s_lane_start(rise, go);
    rise ##1 go;
  endsequence

  AST_GATED_IDLE: assert property (!ungated |-> count_en_w == 16'h0000)
    else $error("lane counted with a nonzero gate time");

  AST_REARM_IGNORED: assert property (ungated && !hold_w |-> count_en_w == en_w)
    else $error("ungated counting did not follow the enables");

  AST_FREEZE_ENTRY: assert property (s_freeze_entry |=> frozen_out && count_en_w == 16'h0000)
    else $error("clear bit did not freeze counting");

  AST_FREEZE_EXIT: assert property (s_clear_pulse |=> !frozen_out)
    else $error("freeze not left when clear bit dropped");

  AST_FREEZE_LEVEL: assert property (clear_error_results_in |=> frozen_out)
    else $error("clear bit high without freeze");

  AST_FROZEN_IDLE: assert property (frozen_out |-> count_en_w == 16'h0000)
    else $error("lane counted in freeze phase");

  AST_TICK_NEEDS_RUN: assert property (tick_w |-> $past(interim_update_capable_in)
      && $past(ungated))
    else $error("refresh tick without interim capability");

  AST_RUN_AFTER_RELEASE: assert property (s_clear_pulse ##1 !clear_error_results_in
      |-> !hold_w)
    else $error("counting not resumed after clear release");

  // Read port: one cycle of latency, data taken straight from the result sets
  AST_READ_PRIMARY: assert property (!rd_prev_in
      |=> rd_err_out == $past(pri_err_reg[rd_lane_in])
      && rd_bits_out == $past(pri_bits_reg[rd_lane_in]))
    else $error("primary result read back wrong");

  AST_READ_PREVIOUS: assert property (rd_prev_in
      |=> rd_err_out == $past(prv_err_reg[rd_lane_in])
      && rd_bits_out == $past(prv_bits_reg[rd_lane_in]))
    else $error("previous result read back wrong");

  for (genvar j = 0; j < `PUM_LANES; j++) begin : g_chk
    AST_ENABLE_CLEARS: assert property (en_rise[j] |=> live_err_w[j] == 32'h0
        && live_bit_w[j] == 48'h0)
      else $error("new enable did not clear lane counters");

    AST_DISABLE_PUBLISH: assert property (en_fall[j] |=> pri_err_reg[j] == $past(live_err_w[j])
        && prv_bits_reg[j] == $past(live_bit_w[j]))
      else $error("disable did not publish lane results");

    AST_NO_REFRESH: assert property (!interim_update_capable_in && !en_fall[j]
        && !clr_rise |=> $stable(pri_err_reg[j]))
      else $error("results changed without interim capability");

    AST_REFRESH: assert property (interim_update_capable_in && tick_w && count_en_w[j]
        |=> pri_err_reg[j] == $past(live_err_w[j]))
      else $error("interim refresh missed");

    AST_GLOBAL_COPY: assert property (clr_rise && scope_w
        |=> prv_err_reg[j] == $past(live_err_w[j]))
      else $error("global clear did not copy previous results");

    AST_PREV_KEPT: assert property (!en_fall[j] && !(clr_rise && scope_w)
        |=> $stable(prv_err_reg[j]) && $stable(prv_bits_reg[j]))
      else $error("previous results changed without a copy event");

    AST_FROZEN_STABLE: assert property (frozen_out && en_w[j] && !clr_fall && !en_rise[j]
        |=> $stable(live_err_w[j]))
      else $error("enabled lane counted while frozen");

    AST_RELEASE_CLEARS: assert property (s_clear_pulse ##0 (en_w[j] || scope_w)
        |=> live_err_w[j] == 32'h0)
      else $error("clear bit release did not clear lane");

    AST_LOCAL_SCOPE: assert property (clr_fall && !scope_w && !en_w[j] && !en_reg[j]
        |=> $stable(live_err_w[j]))
      else $error("local clear disturbed a disabled lane");

    AST_ENABLE_RESTART: assert property (s_lane_start(en_rise[j], count_en_w[j] && err_w[j]
        && !clear_w[j]) |=> live_err_w[j] == 32'h1)
      else $error("newly enabled lane did not restart from zero");

    AST_DISABLE_PAIR: assert property (en_fall[j] |=> pri_bits_reg[j] == $past(live_bit_w[j])
        && prv_err_reg[j] == $past(live_err_w[j]))
      else $error("disable did not publish both counts");

    AST_FREEZE_COPY: assert property (clr_rise && en_w[j]
        |=> pri_err_reg[j] == $past(live_err_w[j])
        && pri_bits_reg[j] == $past(live_bit_w[j]))
      else $error("freeze did not publish enabled lane");

    AST_GLOBAL_PRI: assert property (clr_rise && scope_w
        |=> pri_bits_reg[j] == $past(live_bit_w[j])
        && prv_bits_reg[j] == $past(live_bit_w[j]))
      else $error("global clear did not copy bit counts");

    AST_BITS_STEP: assert property (count_en_w[j] && bit_w[j] && !clear_w[j]
        && live_bit_w[j] != 48'hFFFFFFFFFFFF |=> live_bit_w[j] == $past(live_bit_w[j]) + 48'h1)
      else $error("bit counter did not step by one");

    AST_IDLE_LANE: assert property (!en_w[j] && !clear_w[j]
        |=> $stable(live_err_w[j]) && $stable(live_bit_w[j]))
      else $error("disabled lane counters moved");

    AST_REFRESH_BITS: assert property (interim_update_capable_in && tick_w && count_en_w[j]
        |=> pri_bits_reg[j] == $past(live_bit_w[j]))
      else $error("interim refresh missed bit count");

    AST_RELEASE_BITS: assert property (s_clear_pulse ##0 (en_w[j] || scope_w)
        |=> live_bit_w[j] == 48'h0)
      else $error("clear bit release did not clear bit count");
  end

endmodule

// ---- pum_event_src.sv ----
/*
 * Partner model: the lane checkers that feed error and bit events to the
 * measurement block, driven on the falling edge of clk_in.
 * Assumes pum_cfg.svh on the include path and a bench that calls burst.
 */
`timescale 1ns/1ns
`include "pum_cfg.svh"

module pum_event_src (
  // Clock
  input  wire logic                       clk_in,
  // Checker events
  output logic      [`PUM_SIDE_LANES-1:0] host_err_out,
  output logic      [`PUM_SIDE_LANES-1:0] media_err_out,
  output logic      [`PUM_SIDE_LANES-1:0] host_bit_out,
  output logic      [`PUM_SIDE_LANES-1:0] media_bit_out
);
  initial begin
    host_err_out  = '0;
    media_err_out = '0;
    host_bit_out  = '0;
    media_bit_out = '0;
  end

  // ****************************************************************
  // Event bursts
  // ****************************************************************
  // One event per lane per cycle at most; lines drop to idle after the burst
  task automatic burst(input logic [`PUM_SIDE_LANES-1:0] he, input logic [`PUM_SIDE_LANES-1:0] me,
                       input logic [`PUM_SIDE_LANES-1:0] hb, input logic [`PUM_SIDE_LANES-1:0] mb,
                       input int n);
    repeat (n) begin
      @(negedge clk_in);
      host_err_out  = he;
      media_err_out = me;
      host_bit_out  = hb;
      media_bit_out = mb;
    end
    @(negedge clk_in);
    host_err_out  = '0;
    media_err_out = '0;
    host_bit_out  = '0;
    media_bit_out = '0;
  endtask
endmodule

// ---- tb_pum_top.sv ----
/*
 * Self-checking bench of pum_top: enables, clear bit, scopes, interim refresh
 * and gated codes, results read back by lane index.
 * Assumes the short and long refresh counts 20 and 50 in place of 1 s and 5 s.
 */
`timescale 1ns/1ns
`include "pum_cfg.svh"

module tb_pum_top;
  localparam int SHORT_CYC = 20;
  localparam int LONG_CYC  = 50;

  logic                        clk_in = 1'b0;
  logic                        rst_n_in = 1'b0;
  logic [`PUM_SIDE_LANES-1:0]  host_chk_en_in = '0;
  logic [`PUM_SIDE_LANES-1:0]  media_chk_en_in = '0;
  logic [`PUM_SIDE_LANES-1:0]  host_err, media_err, host_bit, media_bit;
  logic [`PUM_GATE_W-1:0]      gate_time_select_in = 3'h0;
  logic                        gate_auto_rearm_in = 1'b1;
  logic                        interim_update_capable_in = 1'b0;
  logic                        interim_refresh_interval_in = 1'b0;
  logic                        reset_scope_all_banks_in = 1'b0;
  logic                        clear_error_results_in = 1'b0;
  logic [`PUM_LANE_IDX_W-1:0]  rd_lane_in = '0;
  logic                        rd_prev_in = 1'b0;
  logic [`PUM_ERR_W-1:0]       rd_err_out;
  logic [`PUM_BIT_W-1:0]       rd_bits_out;
  logic                        frozen_out;
  int                          fail_count = 0;
  int                          checked = 0;

  pum_top #(.REFRESH_SHORT_CYC(SHORT_CYC), .REFRESH_LONG_CYC(LONG_CYC)) i_pum_top (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .host_chk_en_in(host_chk_en_in), .media_chk_en_in(media_chk_en_in),
    .host_err_in(host_err), .media_err_in(media_err),
    .host_bit_in(host_bit), .media_bit_in(media_bit),
    .gate_time_select_in(gate_time_select_in), .gate_auto_rearm_in(gate_auto_rearm_in),
    .interim_update_capable_in(interim_update_capable_in),
    .interim_refresh_interval_in(interim_refresh_interval_in),
    .reset_scope_all_banks_in(reset_scope_all_banks_in),
    .clear_error_results_in(clear_error_results_in),
    .rd_lane_in(rd_lane_in), .rd_prev_in(rd_prev_in),
    .rd_err_out(rd_err_out), .rd_bits_out(rd_bits_out), .frozen_out(frozen_out));

  pum_event_src i_pum_event_src (
    .clk_in(clk_in), .host_err_out(host_err), .media_err_out(media_err),
    .host_bit_out(host_bit), .media_bit_out(media_bit));

  initial begin
    forever #2 clk_in = ~clk_in;
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Result port is registered: index set in one cycle, data after the next edge
  task automatic rd(input logic [3:0] lane, input logic prev, input logic [31:0] e,
                    input logic [47:0] b);
    rd_lane_in = lane;
    rd_prev_in = prev;
    tick(1);
    chk($sformatf("err lane %0d prev %0d", lane, prev), {16'h0, e}, {16'h0, rd_err_out});
    chk($sformatf("bits lane %0d prev %0d", lane, prev), b, rd_bits_out);
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fail_count++;
    $display("unexpected run length: expected end seen timeout");
    close_out();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    tick(8);
    rst_n_in = 1'b1;
    rd(4'h0, 1'b0, 32'h0, 48'h0);
    done("reset");
    // Enable, count with auto-rearm set, then stop the host lanes
    host_chk_en_in  = 8'h0F;
    media_chk_en_in = 8'h01;
    tick(1);
    i_pum_event_src.burst(8'h05, 8'h01, 8'h0F, 8'h01, 10);
    host_chk_en_in = 8'h00;
    tick(2);
    rd(4'h0, 1'b0, 32'hA, 48'hA);
    rd(4'h1, 1'b0, 32'h0, 48'hA);
    rd(4'h0, 1'b1, 32'hA, 48'hA);
    rd(4'h8, 1'b0, 32'h0, 48'h0);
    done("enable_disable");
    // Local clear: rise freezes, events dropped, fall restarts enabled lanes
    gate_auto_rearm_in = 1'b0;
    clear_error_results_in = 1'b1;
    tick(2);
    chk("frozen", 48'h1, {47'h0, frozen_out});
    rd(4'h8, 1'b0, 32'hA, 48'hA);
    i_pum_event_src.burst(8'h00, 8'h01, 8'h00, 8'h01, 5);
    clear_error_results_in = 1'b0;
    tick(2);
    chk("frozen", 48'h0, {47'h0, frozen_out});
    i_pum_event_src.burst(8'h00, 8'h01, 8'h00, 8'h01, 3);
    media_chk_en_in = 8'h00;
    tick(1);
    rd(4'h8, 1'b0, 32'h3, 48'h3);
    rd(4'h2, 1'b0, 32'hA, 48'hA);
    done("local_clear");
    // Global clear: copy to both result sets, restart, previous kept
    reset_scope_all_banks_in = 1'b1;
    media_chk_en_in = 8'h01;
    tick(1);
    i_pum_event_src.burst(8'h00, 8'h01, 8'h00, 8'h01, 6);
    clear_error_results_in = 1'b1;
    tick(2);
    rd(4'h8, 1'b1, 32'h6, 48'h6);
    clear_error_results_in = 1'b0;
    tick(1);
    i_pum_event_src.burst(8'h00, 8'h01, 8'h00, 8'h01, 2);
    rd(4'h8, 1'b1, 32'h6, 48'h6);
    rd(4'h8, 1'b0, 32'h6, 48'h6);
    media_chk_en_in = 8'h00;
    tick(1);
    rd(4'h8, 1'b0, 32'h2, 48'h2);
    done("global_clear");
    // Interim refresh at the short then the long interval, polled by the host
    reset_scope_all_banks_in  = 1'b0;
    interim_update_capable_in = 1'b1;
    media_chk_en_in = 8'h02;
    tick(1);
    i_pum_event_src.burst(8'h00, 8'h02, 8'h00, 8'h02, 25);
    tick(25);
    rd(4'h9, 1'b0, 32'h19, 48'h19);
    chk("frozen", 48'h0, {47'h0, frozen_out});
    interim_refresh_interval_in = 1'b1;
    media_chk_en_in = 8'h04;
    tick(1);
    i_pum_event_src.burst(8'h00, 8'h04, 8'h00, 8'h04, 10);
    tick(28);
    rd(4'hA, 1'b0, 32'h0, 48'h0);
    tick(15);
    rd(4'hA, 1'b0, 32'hA, 48'hA);
    done("interim");
    // Gated code: no counting at all, a toggled enable restarts one media lane
    interim_update_capable_in = 1'b0;
    gate_time_select_in = 3'h1;
    media_chk_en_in = 8'h08;
    tick(1);
    i_pum_event_src.burst(8'h00, 8'h08, 8'h00, 8'h08, 5);
    media_chk_en_in = 8'h00;
    tick(1);
    rd(4'hB, 1'b0, 32'h0, 48'h0);
    done("gated_code");
    close_out();
  end
endmodule
